// ---- src/hot_swap_pin_control.sv ----
// Purpose: Gate enable, restart hold-off, status flags and multi-function pins
// Assumes: Pins are asynchronous; analog status and host controls are on clock_i
// Notes: Alert outputs are active high here; pad inversion lies outside
module hot_swap_pin_control
    import hot_swap_pkg::*;
#(
    parameter longint unsigned HOLD_CYCLES = RESTART_HOLD_CYCLES,
    parameter int unsigned AUX_WIDTH = 12
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic gate_off_request_n_i,
    input wire logic restart_n_i,
    input wire logic mf1_pin_i,
    input wire logic mf2_pin_i,
    input wire logic [1:0] addr_strap_i,
    input wire analog_status_type analog_i,
    input wire logic [1:0] mf1_mode_i,
    input wire logic [1:0] mf2_mode_i,
    input wire logic general_output_one_i,
    input wire logic general_output_two_i,
    input wire logic [7:0] alert_enable_i,
    input wire logic [7:0] alert_source_i,
    input wire logic serial_data_drive_low_i,
    input wire logic serial_data_in_pin_i,
    input wire logic aux_sample_valid_i,
    input wire logic [AUX_WIDTH-1:0] aux_sample_i,
    output logic gate_enable_o,
    output logic mf1_out_o,
    output logic mf1_oe_o,
    output logic mf2_out_o,
    output logic serial_data_out_pin_o,
    output logic serial_data_in_o,
    output logic sample_start_o,
    output logic load_powered_flag_o,
    output logic supply_in_window_flag_n_o,
    output logic latch_fault_o,
    output logic retry_fail_o,
    output logic [1:0] retry_scheme_o,
    output logic [6:0] bus_addr_o,
    output logic [AUX_WIDTH-1:0] aux_value_o
);
    localparam int CW = $clog2(HOLD_CYCLES + 1);

    // Hold-off shorter than seven cycles breaks the hold assertion window
    if (HOLD_CYCLES < 8 || AUX_WIDTH < 1) begin : bad_params_gen
        $error("hot_swap_pin_control: bad parameters");
    end

    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic [1:0] strap1_reg;
    logic [1:0] strap2_reg;
    logic restart_prev_reg;
    logic trig_prev_reg;
    logic serial_sync1_reg;
    logic serial_sync2_reg;
    logic strap_taken_reg;
    logic [CW-1:0] hold_count_reg;
    logic [2:0] retry_count_reg;
    gate_state_type state_reg;
    gate_state_type state_next;
    logic window_ok;
    logic shutdown;
    logic restart_fall;
    logic trig_rise;
    logic alert_any;

    // Two-stage synchronisers for shutdown, restart, pin one and pin two
    // No reset: strap levels must already be settled when reset is released
    always_ff @(posedge clock_i) begin
        sync1_reg <= {mf2_pin_i, mf1_pin_i, restart_n_i, gate_off_request_n_i};
        sync2_reg <= sync1_reg;
    end

    // Edge history follows the pins through reset, so no false edge follows it
    always_ff @(posedge clock_i) begin
        restart_prev_reg <= sync2_reg[1];
        trig_prev_reg <= sync2_reg[2];
    end

    assign shutdown = ~sync2_reg[0];
    assign restart_fall = restart_prev_reg & ~sync2_reg[1];
    assign trig_rise = sync2_reg[2] & ~trig_prev_reg;
    assign window_ok = ~analog_i.under_voltage & ~analog_i.over_voltage;

    // Address strap synchroniser runs through reset as well
    always_ff @(posedge clock_i) begin
        strap1_reg <= addr_strap_i;
        strap2_reg <= strap1_reg;
    end

    // Straps captured once after reset release
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            strap_taken_reg <= 1'h0;
            retry_scheme_o <= 2'h0;
            bus_addr_o <= BUS_ADDR_0;
        end else begin
            if (!strap_taken_reg) begin
                strap_taken_reg <= 1'h1;
                // Scheme from the static shutdown, restart and pin two levels
                retry_scheme_o <= {sync2_reg[0] & sync2_reg[1], sync2_reg[3]};
                if (strap2_reg == 2'h0) begin
                    bus_addr_o <= BUS_ADDR_0;
                end else if (strap2_reg == 2'h1) begin
                    bus_addr_o <= BUS_ADDR_1;
                end else if (strap2_reg == 2'h2) begin
                    bus_addr_o <= BUS_ADDR_2;
                end else begin
                    bus_addr_o <= BUS_ADDR_3;
                end
            end
        end
    end

    // Gate state machine
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF: begin
                if (window_ok && !shutdown) begin
                    state_next = ST_ON;
                end
            end
            ST_ON: begin
                if (analog_i.overcurrent && retry_scheme_o == 2'h0) begin
                    state_next = ST_LATCHED;
                end else if (analog_i.overcurrent) begin
                    state_next = ST_OFF;
                end
            end
            ST_HOLD: begin
                if (hold_count_reg == CW'(HOLD_CYCLES - 1)) begin
                    state_next = ST_OFF;
                end
            end
            ST_LATCHED: begin
                state_next = ST_LATCHED;
            end
            default: begin
                state_next = ST_OFF;
            end
        endcase
        if (restart_fall) begin
            state_next = ST_HOLD;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state_reg <= ST_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // Hold-off counter
    always_ff @(posedge clock_i) begin
        if (rst_i || state_reg != ST_HOLD || restart_fall) begin
            hold_count_reg <= '0;
        end else begin
            hold_count_reg <= hold_count_reg + CW'(1);
        end
    end

    // Retry attempt counter for the seven-attempt flag
    always_ff @(posedge clock_i) begin
        if (rst_i || restart_fall) begin
            retry_count_reg <= 3'h0;
        end else if (state_reg == ST_ON && analog_i.overcurrent && retry_count_reg != RETRY_LIMIT_3) begin
            retry_count_reg <= retry_count_reg + 3'h1;
        end
    end

    assign alert_any = |(alert_enable_i & alert_source_i);

    // Registered pin and status outputs
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            gate_enable_o <= 1'h0;
            load_powered_flag_o <= 1'h0;
            supply_in_window_flag_n_o <= 1'h1;
            latch_fault_o <= 1'h0;
            retry_fail_o <= 1'h0;
            mf1_out_o <= 1'h0;
            mf2_out_o <= 1'h0;
            sample_start_o <= 1'h0;
        end else begin
            gate_enable_o <= (state_next == ST_ON) && !shutdown && window_ok;
            load_powered_flag_o <= (state_next == ST_ON) && !analog_i.fet_linear
                && analog_i.load_charged;
            supply_in_window_flag_n_o <= ~window_ok;
            latch_fault_o <= state_next == ST_LATCHED;
            retry_fail_o <= retry_count_reg == RETRY_LIMIT_3;
            sample_start_o <= (mf1_mode_i == MODE_TRIGGER) && trig_rise;
            if (mf1_mode_i == MODE_GPO) begin
                mf1_out_o <= general_output_one_i;
            end else if (mf1_mode_i == MODE_ALERT) begin
                mf1_out_o <= alert_any;
            end else begin
                mf1_out_o <= analog_i.fet_unhealthy;
            end
            if (mf2_mode_i == MODE_GPO) begin
                mf2_out_o <= general_output_two_i;
            end else if (mf2_mode_i == MODE_ALERT) begin
                mf2_out_o <= alert_any;
            end else begin
                mf2_out_o <= retry_count_reg == RETRY_LIMIT_3;
            end
        end
    end

    assign mf1_oe_o = mf1_mode_i != MODE_TRIGGER;

    // Split serial data: separate input sync and output drive
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            serial_sync1_reg <= 1'h1;
            serial_sync2_reg <= 1'h1;
            serial_data_out_pin_o <= 1'h1;
        end else begin
            serial_sync1_reg <= serial_data_in_pin_i;
            serial_sync2_reg <= serial_sync1_reg;
            serial_data_out_pin_o <= ~serial_data_drive_low_i;
        end
    end
    assign serial_data_in_o = serial_sync2_reg;

    // Auxiliary channel readback
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            aux_value_o <= '0;
        end else if (aux_sample_valid_i) begin
            aux_value_o <= aux_sample_i;
        end
    end

    AST_GATE_OFF_REQ: assert property (@(posedge clock_i) disable iff (rst_i)
        !sync2_reg[0] |=> !gate_enable_o) else $error("gate on during shutdown");
    AST_WINDOW_GATE: assert property (@(posedge clock_i) disable iff (rst_i)
        !window_ok |=> !gate_enable_o) else $error("gate on outside window");
    AST_HOLD_OFF: assert property (@(posedge clock_i) disable iff (rst_i)
        restart_fall |=> !gate_enable_o [*8]) else $error("gate on during hold");
    AST_HOLD_END: assert property (@(posedge clock_i) disable iff (rst_i)
        state_reg == ST_HOLD && hold_count_reg == CW'(HOLD_CYCLES - 1) && !restart_fall
        |=> state_reg == ST_OFF) else $error("hold did not end");
    AST_PGOOD: assert property (@(posedge clock_i) disable iff (rst_i)
        load_powered_flag_o |-> $past(analog_i.load_charged) && !$past(analog_i.fet_linear))
        else $error("power good too early");
    // The flag still shows its reset value at the first edge after release
    AST_SUPPLY: assert property (@(posedge clock_i) disable iff (rst_i)
        !$past(rst_i) |-> supply_in_window_flag_n_o == !$past(window_ok)) else $error("supply flag wrong");
    AST_ALERT: assert property (@(posedge clock_i) disable iff (rst_i)
        mf1_mode_i == MODE_ALERT && alert_any |=> mf1_out_o || $past(mf1_mode_i) != MODE_ALERT)
        else $error("alert missed");
    AST_LATCH: assert property (@(posedge clock_i) disable iff (rst_i)
        latch_fault_o && !restart_fall |=> latch_fault_o) else $error("latch lost");
    AST_RETRY: assert property (@(posedge clock_i) disable iff (rst_i)
        mf2_mode_i == MODE_HEALTH && retry_count_reg == RETRY_LIMIT_3 && $stable(mf2_mode_i)
        |=> mf2_out_o) else $error("retry flag missing");
    AST_SAMPLE_START: assert property (@(posedge clock_i) disable iff (rst_i)
        sample_start_o |-> $past(mf1_mode_i) == MODE_TRIGGER) else $error("bad sample start");

    COV_RESTART: cover property (@(posedge clock_i) disable iff (rst_i) restart_fall ##1 state_reg == ST_HOLD);
    COV_POWERED: cover property (@(posedge clock_i) disable iff (rst_i) load_powered_flag_o);
    COV_LATCH: cover property (@(posedge clock_i) disable iff (rst_i) latch_fault_o);
    COV_SAMPLE: cover property (@(posedge clock_i) disable iff (rst_i) sample_start_o);
endmodule : hot_swap_pin_control

// ---- common/hot_swap_pkg.sv ----
// Purpose: Shared constants and carriers for the hot swap pin control block
// Assumes: 250 MHz core clock
// Notes: Long counts are module parameters derived from these constants
package hot_swap_pkg;
    localparam int unsigned CLOCK_HZ = 250_000_000;
    // Restart hold-off time in seconds
    localparam int unsigned RESTART_HOLD_SEC = 10;
    localparam longint unsigned RESTART_HOLD_CYCLES = longint'(RESTART_HOLD_SEC) * longint'(CLOCK_HZ);
    // Retry attempts before the seven-attempt fail flag
    localparam int unsigned RETRY_LIMIT = 7;
    localparam logic [2:0] RETRY_LIMIT_3 = 3'h7;
    // Multi-function pin modes
    localparam logic [1:0] MODE_HEALTH = 2'h0;
    localparam logic [1:0] MODE_GPO = 2'h1;
    localparam logic [1:0] MODE_ALERT = 2'h2;
    localparam logic [1:0] MODE_TRIGGER = 2'h3;
    // Fixed management bus addresses selected by the address strap
    localparam logic [6:0] BUS_ADDR_0 = 7'h10;
    localparam logic [6:0] BUS_ADDR_1 = 7'h12;
    localparam logic [6:0] BUS_ADDR_2 = 7'h14;
    localparam logic [6:0] BUS_ADDR_3 = 7'h16;

    // Analog comparator status from the front end
    typedef struct packed {
        logic under_voltage;
        logic over_voltage;
        logic fet_linear;
        logic load_charged;
        logic overcurrent;
        logic fet_unhealthy;
    } analog_status_type;

    // Gate control state
    typedef enum logic [3:0] {
        ST_OFF = 4'h1,
        ST_ON = 4'h2,
        ST_HOLD = 4'h4,
        ST_LATCHED = 4'h8
    } gate_state_type;
endpackage : hot_swap_pkg

// ---- verification/hot_swap_fet_model.sv ----
// Purpose: Pass FET and supply model that feeds the analog status
// Assumes: The load charges only while the gate drive is on
// Notes: fault_i is {under, over, overcurrent, unhealthy} from the bench
module hot_swap_fet_model
    import hot_swap_pkg::*;
#(
    parameter int CHARGE = 8
) (
    input wire logic clock_i,
    input wire logic gate_enable_i,
    input wire logic [3:0] fault_i,
    output analog_status_type analog_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int count_reg = 0;
    // Charge timer restarts whenever the gate drops
    always_ff @(posedge clock_i) begin
        count_reg <= !gate_enable_i ? 0 : (count_reg < CHARGE ? count_reg + 1 : count_reg);
    end
    // FET stays linear while charging, then the load reads charged
    always_comb begin
        analog_o = {fault_i[3:2], gate_enable_i && count_reg < CHARGE, count_reg == CHARGE, fault_i[1:0]};
    end
endmodule : hot_swap_fet_model

// ---- verification/hot_swap_pin_control_tb_top.sv ----
// Purpose: Self-checking bench for the hot swap pin control block
// Assumes: Hold-off shortened to 20 cycles; inputs change on falling edges
// Notes: Trigger pulses and auxiliary loads are matched through queues
module hot_swap_pin_control_tb_top
    import hot_swap_pkg::*;
#(parameter longint unsigned HOLD = 20);
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 0, rst_i = 1, off_req_n = 1, restart_n = 1, mf1_pin = 0, mf2_pin = 1;
    logic out_one = 0, out_two = 0, sdl = 0, sdin = 1, aval = 0;
    logic [1:0] strap = 0, mode1 = 0, mode2 = 0, aux_age = 0;
    logic [7:0] aen = 0, asrc = 0;
    logic [11:0] aux = 0, auxo;
    logic [3:0] fault = 0;
    logic gate, mf1_out, mf1_oe, mf2_out, sdo, sdi_o, sstart, pwr, sup_n, latch, rfail;
    logic [1:0] scheme;
    logic [6:0] addr;
    logic [15:0] lfsr = 16'h6F2C;
    analog_status_type analog;
    int failures = 0, checks = 0, cyc = 0;
    int start_q[$];
    logic [11:0] aux_q[$];

    hot_swap_fet_model fet (.clock_i(clock_i), .gate_enable_i(gate), .fault_i(fault), .analog_o(analog));
    hot_swap_pin_control #(.HOLD_CYCLES(HOLD)) uut (.clock_i(clock_i), .rst_i(rst_i),
        .gate_off_request_n_i(off_req_n), .restart_n_i(restart_n), .mf1_pin_i(mf1_pin), .mf2_pin_i(mf2_pin),
        .addr_strap_i(strap), .analog_i(analog), .mf1_mode_i(mode1), .mf2_mode_i(mode2),
        .general_output_one_i(out_one), .general_output_two_i(out_two), .alert_enable_i(aen),
        .alert_source_i(asrc), .serial_data_drive_low_i(sdl), .serial_data_in_pin_i(sdin),
        .aux_sample_valid_i(aval), .aux_sample_i(aux), .gate_enable_o(gate), .mf1_out_o(mf1_out),
        .mf1_oe_o(mf1_oe), .mf2_out_o(mf2_out), .serial_data_out_pin_o(sdo), .serial_data_in_o(sdi_o),
        .sample_start_o(sstart), .load_powered_flag_o(pwr), .supply_in_window_flag_n_o(sup_n),
        .latch_fault_o(latch), .retry_fail_o(rfail), .retry_scheme_o(scheme), .bus_addr_o(addr),
        .aux_value_o(auxo));

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        checks++;
        if (seen !== want) begin
            failures++;
            $display("ERROR %0t seen %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic end_sim();
        if (failures == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim
    function automatic logic [15:0] step(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : step
    task automatic tick(input int n);
        repeat (n) @(negedge clock_i);
    endtask : tick
    task automatic wait_gate(input logic v);
        for (int i = 0; i < 60 && gate !== v; i++) @(negedge clock_i);
        check(gate, v);
    endtask : wait_gate
    task automatic do_reset(input logic [1:0] s, input logic m2, input logic sd);
        strap = s;
        mf2_pin = m2;
        off_req_n = sd;
        rst_i = 1'b1;
        tick(3);
        rst_i = 1'b0;
        tick(2);
        check(addr, BUS_ADDR_0 + 7'(2 * s));
        check(scheme, {sd & restart_n, m2});
    endtask : do_reset

    // Clock, cycle count, hang limit and auxiliary load age
    initial begin
        forever #2 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cyc++;
        aux_age <= aval ? 2'h1 : {aux_age == 2'h1, 1'b0};
        if (cyc == 5000) begin
            failures++;
            end_sim();
        end
    end
    // Result watcher takes the oldest note when a result shows
    always @(negedge clock_i) begin
        if (sstart === 1'b1) check(16'(cyc), 16'(start_q.size() ? start_q.pop_front() : 0));
        if (aux_age == 2'h2) check(auxo, aux_q.size() ? aux_q.pop_front() : 'x);
    end

    // Main sequence
    initial begin
        for (int s = 0; s < 4; s++) do_reset(2'(s), s[0], 1'b1);
        wait_gate(1'b1);
        check({sup_n, pwr}, 2'h0);
        tick(12);
        check(pwr, 1'b1);
        fault = 4'h1;
        tick(2);
        check({mf1_oe, mf1_out}, 2'h3);
        for (int b = 2; b < 4; b++) begin
            fault = 4'(1 << b);
            tick(3);
            check({gate, sup_n, pwr}, 3'h2);
            fault = 4'h0;
            wait_gate(1'b1);
            check(sup_n, 1'b0);
        end
        off_req_n = 1'b0;
        tick(2);
        check(gate, 1'b1);
        tick(1);
        check(gate, 1'b0);
        off_req_n = 1'b1;
        // Retry scheme re-powers at once, so the gate is off for one cycle only
        for (int n = 1; n <= 7; n++) begin
            wait_gate(1'b1);
            check(rfail, 1'b0);
            fault[1] = 1'b1;
            tick(1);
            fault[1] = 1'b0;
            check({gate, latch}, 2'h0);
        end
        tick(2);
        check({rfail, mf2_out}, 2'h3);
        restart_n = 1'b0;
        tick(3);
        check({gate, latch}, 2'h0);
        tick(int'(HOLD) - 1);
        check(gate, 1'b0);
        restart_n = 1'b1;
        wait_gate(1'b1);
        // Random output, alert, serial and auxiliary traffic
        for (int k = 0; k < 16; k++) begin
            lfsr = step(lfsr);
            aen = lfsr[15:8];
            asrc = lfsr[7:0];
            lfsr = step(lfsr);
            aux = lfsr[11:0];
            mode1 = lfsr[12] ? MODE_GPO : MODE_ALERT;
            mode2 = lfsr[13] ? MODE_GPO : MODE_ALERT;
            {out_two, out_one, sdin, sdl} = {lfsr[15:14], lfsr[1:0]};
            aval = 1'b1;
            aux_q.push_back(aux);
            tick(1);
            aval = 1'b0;
            tick(2);
            check(mf1_out, mode1 == MODE_GPO ? out_one : |(aen & asrc));
            check({mf1_oe, mf2_out}, {1'b1, mode2 == MODE_GPO ? out_two : |(aen & asrc)});
            check({sdo, sdi_o}, {~sdl, sdin});
        end
        mode1 = MODE_TRIGGER;
        tick(1);
        check(mf1_oe, 1'b0);
        repeat (3) begin
            mf1_pin = 1'b1;
            start_q.push_back(cyc + 3);
            tick(4);
            mf1_pin = 1'b0;
            tick(4);
        end
        check(16'(start_q.size()), 16'h0);
        // Latch-off scheme, cleared by a restart edge
        do_reset(2'h0, 1'b0, 1'b0);
        off_req_n = 1'b1;
        wait_gate(1'b1);
        fault[1] = 1'b1;
        tick(1);
        fault[1] = 1'b0;
        tick(12);
        check({gate, latch}, 2'h1);
        restart_n = 1'b0;
        tick(4);
        check(latch, 1'b0);
        restart_n = 1'b1;
        check(16'(aux_q.size()), 16'h0);
        end_sim();
    end
endmodule : hot_swap_pin_control_tb_top
